// ### bsc_pkg.sv
// Package: constants, pin bundles and states of the block
package bsc_pkg;

    // Clock rate and the two supervisory times
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned ACT_TIMEOUT_MS = 3000;
    localparam int unsigned TMR_TIMEOUT_MS = 1000;
    localparam int unsigned ACT_TIMEOUT_CYCLES = ACT_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned TMR_TIMEOUT_CYCLES = TMR_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 25;

    // Register byte offsets
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h04;
    localparam logic [7:0] OFS_INPUT_STATUS = 8'h08;
    localparam logic [7:0] OFS_START_ADDR = 8'h0C;
    localparam logic [7:0] OFS_TERM_ADDR = 8'h10;
    localparam logic [7:0] OFS_CURRENT_ADDR = 8'h14;

    // Command register bit positions (write one to issue)
    localparam int CMD_TRANSMIT = 0;
    localparam int CMD_RECEIVE = 1;
    localparam int CMD_TIMER_START = 2;
    localparam int CMD_TIMER_ABORT = 3;
    localparam int CMD_TIMER_RESET = 4;
    localparam int CMD_RING_INT_ON = 5;
    localparam int CMD_RING_INT_OFF = 6;
    localparam int CMD_DEVICE_CLEAR = 7;
    localparam int CMD_HOST_INIT = 8;

    // Input status flag positions
    localparam int ST_NOT_BUSY = 7;
    localparam int ST_TIMER_TIMEOUT = 4;
    localparam int ST_ACT_TIMEOUT = 3;
    localparam int ST_CLEAR_TO_SEND = 2;
    localparam int ST_DATA_SET_READY = 1;
    localparam int ST_RING_DETECTED = 0;

    // Output control flag positions and reset value
    localparam int OC_RING_DETECT_MODE = 0;
    localparam int OC_DTR = 4;
    localparam int OC_SEVEN_BIT = 5;
    localparam int OC_LRC = 6;
    localparam logic [7:0] OC_RESET = 8'h00;

    // Character framing
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic MARK = 1'b1;
    localparam logic [15:0] ADDR_RESET = 16'h0000;

    // Modem pins toward the block
    typedef struct packed {
        logic txc;
        logic cts;
        logic dsr;
        logic ri;
    } bsc_modem_in_s;

    // Modem pins driven by the block
    typedef struct packed {
        logic rts;
        logic dtr;
        logic txd;
    } bsc_modem_out_s;

    // Transmit sequencer states
    typedef enum logic [5:0] {
        TX_IDLE = 6'b000001,
        TX_WAIT_CTS = 6'b000010,
        TX_FETCH = 6'b000100,
        TX_LOAD = 6'b001000,
        TX_SHIFT = 6'b010000,
        TX_DRAIN = 6'b100000
    } bsc_tx_state_e;

endpackage

// ### bsc_ctrl.sv
// Sync transmit, modem handshake, timers and status flags behind an AHB-Lite slave
// Operation
// - Transmit command clears not-busy (bit 7) and raises request to send.
// - No data leaves the main channel until clear to send is seen.
// - Current address loads from start, advances per character, stops at terminating.
// - Reaching terminating address ends transmit, sets not-busy, drops request to send.
// - Host init or device clear aborts transmit, sets not-busy, drops request to send.
// - Interrupt requested while not-busy is set, not on its account when clear.
// - With request to send low, transmitted data sits at mark despite clocks.
// - In ring detect mode a rising ring indicator sets ring-detected (bit 0).
// - Ring-detected stays latched after ring indicator drops; only clears reset it.
// - Host init or device clear resets ring-detected even in ring detect mode.
// - Transmit/receive command leaves ring-detected unchanged.
// - Ring-detected sets even when ring interrupt mode is off.
// - Ring-interrupt-off command may clear ring interrupt mode; flag effect unconfirmed.
// - Activity timeout (bit 3) sets about 3 s after idle receive or transmit.
// - Activity timeout sets no sooner than 2.4 s, no later than 3.6 s.
// - Init, clear or transmit/receive reset activity flag; command restarts timing.
// - Start-timer sets timer-timeout (bit 4) about 1 s later.
// - Timer-timeout sets no sooner than 0.8 s, no later than 1.2 s.
// - Init, clear, abort, reset and start timer each clear timer-timeout.
// - Interrupt requested while timer-timeout is set, not on its account when clear.
// - Seven-bit mode sends low 7 bits plus parity; control bit 6 selects LRC.
// - Data terminal ready follows control bit 4; init or clear drops it.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module bsc_ctrl #(
    parameter int unsigned ACT_CYCLES = bsc_pkg::ACT_TIMEOUT_CYCLES,
    parameter int unsigned TMR_CYCLES = bsc_pkg::TMR_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Buffer memory read port, byte taken at the end of the strobe cycle
    output logic [15:0] mem_addr_out,
    output logic mem_rd_out,
    input wire logic [7:0] mem_rdata_in,
    // Modem pins
    input wire bsc_pkg::bsc_modem_in_s modem_in,
    output bsc_pkg::bsc_modem_out_s modem_out,
    // Interrupt request, level
    output logic irq_out
);
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [11:0] sync_reg;
    bsc_pkg::bsc_modem_in_s pin_reg;
    bsc_pkg::bsc_modem_in_s pin_prev_reg;
    logic [7:0] out_ctl_reg;
    logic [15:0] start_addr_reg;
    logic [15:0] term_addr_reg;
    logic [15:0] cur_addr_reg;
    bsc_pkg::bsc_tx_state_e tx_state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic last_char_reg;
    logic bcc_pend_reg;
    logic [6:0] lrc_reg;
    logic not_busy_reg;
    logic ring_det_reg;
    logic ring_int_mode_reg;
    logic act_run_reg;
    logic act_flag_reg;
    logic [bsc_pkg::CNT_W-1:0] act_cnt_reg;
    logic tmr_run_reg;
    logic tmr_flag_reg;
    logic [bsc_pkg::CNT_W-1:0] tmr_cnt_reg;
    logic addr_phase;
    logic addr_ok;
    logic cmd_wr;
    logic [8:0] cmd;
    logic clr;
    logic txc_fall;
    logic ri_rise;
    logic act_expire;
    logic tmr_expire;
    logic [7:0] status;
    logic [7:0] char_word;

    // Bus decode; upper address bits must be zero for a register hit
    assign addr_phase = hsel_in && hready_in && htrans_in[1];
    assign addr_ok = (haddr_in[31:8] == 24'h000000) && (haddr_in[1:0] == 2'h0);
    assign cmd_wr = wr_pend_reg && (wr_ofs_reg == bsc_pkg::OFS_COMMAND);
    assign cmd = cmd_wr ? hwdata_in[8:0] : 9'h000;
    // Init and clear act in the very cycle of the write
    assign clr = cmd[bsc_pkg::CMD_HOST_INIT] || cmd[bsc_pkg::CMD_DEVICE_CLEAR];
    // Edges are taken from the filtered copy, never from the first stage
    assign txc_fall = pin_prev_reg.txc && !pin_reg.txc;
    assign ri_rise = !pin_prev_reg.ri && pin_reg.ri;
    assign act_expire = act_run_reg
        && (act_cnt_reg == bsc_pkg::CNT_W'(ACT_CYCLES - 1));
    assign tmr_expire = tmr_run_reg
        && (tmr_cnt_reg == bsc_pkg::CNT_W'(TMR_CYCLES - 1));
    // Status byte as software sees it, bits 7 down to 0
    assign status = {not_busy_reg, 2'b00, tmr_flag_reg, act_flag_reg, pin_reg.cts, pin_reg.dsr,
        ring_det_reg};
    // Seven-bit mode replaces bit 7 with odd parity over the low seven bits
    always_comb
    begin
        char_word = mem_rdata_in;
        if (bcc_pend_reg && last_char_reg)
        begin
            char_word = {1'b0, lrc_reg};
        end
        if (out_ctl_reg[bsc_pkg::OC_SEVEN_BIT])
        begin
            char_word[7] = ~^char_word[6:0];
        end
    end
    // Bus slave: zero wait states, always OKAY, read data registered in address phase
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
            hrdata_out <= 32'h00000000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
        else
        begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite_in && addr_ok;
            wr_ofs_reg <= haddr_in[7:0];
            hrdata_out <= 32'h00000000;
            if (addr_phase && !hwrite_in && addr_ok)
            begin
                if (haddr_in[7:0] == bsc_pkg::OFS_OUTPUT_CONTROL)
                    hrdata_out <= {24'h000000, out_ctl_reg};
                else if (haddr_in[7:0] == bsc_pkg::OFS_INPUT_STATUS)
                    hrdata_out <= {24'h000000, status};
                else if (haddr_in[7:0] == bsc_pkg::OFS_START_ADDR)
                    hrdata_out <= {16'h0000, start_addr_reg};
                else if (haddr_in[7:0] == bsc_pkg::OFS_TERM_ADDR)
                    hrdata_out <= {16'h0000, term_addr_reg};
                else if (haddr_in[7:0] == bsc_pkg::OFS_CURRENT_ADDR)
                    hrdata_out <= {16'h0000, cur_addr_reg};
            end
        end
    end
    // Software-written registers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            out_ctl_reg <= bsc_pkg::OC_RESET;
            start_addr_reg <= bsc_pkg::ADDR_RESET;
            term_addr_reg <= bsc_pkg::ADDR_RESET;
        end
        else
        begin
            if (wr_pend_reg && wr_ofs_reg == bsc_pkg::OFS_OUTPUT_CONTROL)
                out_ctl_reg <= hwdata_in[7:0];
            else if (wr_pend_reg && wr_ofs_reg == bsc_pkg::OFS_START_ADDR)
                start_addr_reg <= hwdata_in[15:0];
            else if (wr_pend_reg && wr_ofs_reg == bsc_pkg::OFS_TERM_ADDR)
                term_addr_reg <= hwdata_in[15:0];
            if (clr)
                out_ctl_reg[bsc_pkg::OC_DTR] <= 1'b0;
        end
    end
    // Modem inputs: three stages; stages two and three must agree
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync_reg <= 12'h000;
            pin_reg <= '0;
            pin_prev_reg <= '0;
        end
        else
        begin
            sync_reg <= {sync_reg[7:0], modem_in};
            pin_reg <= (sync_reg[7:4] & sync_reg[11:8])
                | (pin_reg & (sync_reg[7:4] | sync_reg[11:8]));
            pin_prev_reg <= pin_reg;
        end
    end
    // Transmit sequencer; the modem clock's falling edge launches each bit
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tx_state_reg <= bsc_pkg::TX_IDLE;
            not_busy_reg <= 1'b1;
            cur_addr_reg <= bsc_pkg::ADDR_RESET;
            shift_reg <= 8'hFF;
            bit_cnt_reg <= 4'h0;
            last_char_reg <= 1'b0;
            bcc_pend_reg <= 1'b0;
            lrc_reg <= 7'h00;
            mem_rd_out <= 1'b0;
            mem_addr_out <= bsc_pkg::ADDR_RESET;
            modem_out <= '{rts: 1'b0, dtr: 1'b0, txd: bsc_pkg::MARK};
        end
        else
        begin
            mem_rd_out <= 1'b0;
            modem_out.dtr <= out_ctl_reg[bsc_pkg::OC_DTR] && !clr;
            if (clr)
            begin
                tx_state_reg <= bsc_pkg::TX_IDLE;
                not_busy_reg <= 1'b1;
                modem_out.rts <= 1'b0;
                modem_out.txd <= bsc_pkg::MARK;
            end
            else if (cmd[bsc_pkg::CMD_TRANSMIT])
            begin
                tx_state_reg <= bsc_pkg::TX_WAIT_CTS;
                not_busy_reg <= 1'b0;
                modem_out.rts <= 1'b1;
                modem_out.txd <= bsc_pkg::MARK;
            end
            else
            begin
                case (tx_state_reg)
                    bsc_pkg::TX_IDLE:
                        modem_out.txd <= bsc_pkg::MARK;
                    bsc_pkg::TX_WAIT_CTS:
                    begin
                        if (pin_reg.cts)
                        begin
                            cur_addr_reg <= start_addr_reg;
                            lrc_reg <= 7'h00;
                            bcc_pend_reg <= out_ctl_reg[bsc_pkg::OC_LRC]
                                && out_ctl_reg[bsc_pkg::OC_SEVEN_BIT];
                            last_char_reg <= 1'b0;
                            tx_state_reg <= bsc_pkg::TX_FETCH;
                        end
                    end
                    bsc_pkg::TX_FETCH:
                    begin
                        mem_addr_out <= cur_addr_reg;
                        mem_rd_out <= !(bcc_pend_reg && last_char_reg);
                        tx_state_reg <= bsc_pkg::TX_LOAD;
                    end
                    bsc_pkg::TX_LOAD:
                    begin
                        shift_reg <= char_word;
                        if (!(bcc_pend_reg && last_char_reg))
                            lrc_reg <= lrc_reg ^ mem_rdata_in[6:0];
                        bit_cnt_reg <= 4'h0;
                        tx_state_reg <= bsc_pkg::TX_SHIFT;
                    end
                    bsc_pkg::TX_SHIFT:
                    begin
                        if (txc_fall)
                        begin
                            modem_out.txd <= shift_reg[0];
                            shift_reg <= {bsc_pkg::MARK, shift_reg[7:1]};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == bsc_pkg::LAST_BIT)
                            begin
                                if (last_char_reg && bcc_pend_reg)
                                    tx_state_reg <= bsc_pkg::TX_DRAIN;
                                else if (cur_addr_reg == term_addr_reg)
                                begin
                                    if (bcc_pend_reg)
                                    begin
                                        last_char_reg <= 1'b1;
                                        tx_state_reg <= bsc_pkg::TX_FETCH;
                                    end
                                    else
                                        tx_state_reg <= bsc_pkg::TX_DRAIN;
                                end
                                else
                                begin
                                    cur_addr_reg <= cur_addr_reg + 16'h0001;
                                    tx_state_reg <= bsc_pkg::TX_FETCH;
                                end
                            end
                        end
                    end
                    bsc_pkg::TX_DRAIN:
                    begin
                        // Hold the last bit one full modem clock before ending
                        if (txc_fall)
                        begin
                            tx_state_reg <= bsc_pkg::TX_IDLE;
                            not_busy_reg <= 1'b1;
                            modem_out.rts <= 1'b0;
                            modem_out.txd <= bsc_pkg::MARK;
                        end
                    end
                    default:
                        tx_state_reg <= bsc_pkg::TX_IDLE;
                endcase
            end
        end
    end
    // Ring detected: latched on a rising ring indicator, cleared only by init or clear
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ring_det_reg <= 1'b0;
            ring_int_mode_reg <= 1'b0;
        end
        else
        begin
            // Ring interrupt mode only gates the interrupt, never the flag
            if (out_ctl_reg[bsc_pkg::OC_RING_DETECT_MODE] && ri_rise)
                ring_det_reg <= 1'b1;
            else if (clr)
                ring_det_reg <= 1'b0;
            // Leaving ring interrupt mode keeps the flag until confirmed otherwise
            if (clr || cmd[bsc_pkg::CMD_RING_INT_OFF])
                ring_int_mode_reg <= 1'b0;
            else if (cmd[bsc_pkg::CMD_RING_INT_ON])
                ring_int_mode_reg <= 1'b1;
        end
    end
    // Activity timer: runs from a command until a character is sent
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            act_run_reg <= 1'b0;
            act_cnt_reg <= '0;
            act_flag_reg <= 1'b0;
        end
        else
        begin
            if (clr)
            begin
                act_run_reg <= 1'b0;
                act_flag_reg <= act_expire;
            end
            else if (cmd[bsc_pkg::CMD_TRANSMIT] || cmd[bsc_pkg::CMD_RECEIVE])
            begin
                act_run_reg <= 1'b1;
                act_cnt_reg <= '0;
                act_flag_reg <= 1'b0;
            end
            else if (act_expire)
            begin
                act_run_reg <= 1'b0;
                act_flag_reg <= 1'b1;
            end
            else if (tx_state_reg == bsc_pkg::TX_SHIFT && txc_fall
                && bit_cnt_reg == bsc_pkg::LAST_BIT)
                act_run_reg <= 1'b0;
            else if (act_run_reg)
                act_cnt_reg <= act_cnt_reg + 1'b1;
        end
    end
    // One-second timer; an expiry in the cycle of a clear still sets the flag
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tmr_run_reg <= 1'b0;
            tmr_cnt_reg <= '0;
            tmr_flag_reg <= 1'b0;
        end
        else
        begin
            if (cmd[bsc_pkg::CMD_TIMER_START] && !clr)
            begin
                tmr_run_reg <= 1'b1;
                tmr_cnt_reg <= '0;
                tmr_flag_reg <= tmr_expire;
            end
            else if (tmr_expire)
            begin
                tmr_run_reg <= 1'b0;
                tmr_flag_reg <= 1'b1;
            end
            else if (clr || cmd[bsc_pkg::CMD_TIMER_ABORT] || cmd[bsc_pkg::CMD_TIMER_RESET])
            begin
                tmr_run_reg <= 1'b0;
                tmr_flag_reg <= 1'b0;
            end
            else if (tmr_run_reg)
                tmr_cnt_reg <= tmr_cnt_reg + 1'b1;
        end
    end
    // Interrupt is a plain level from the flags
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            irq_out <= 1'b0;
        else
            irq_out <= not_busy_reg || tmr_flag_reg
                || (ring_det_reg && ring_int_mode_reg);
    end
endmodule

// ### bsc_chk.sv
// Checker of the block's port relations
`timescale 1ns/1ps
module bsc_chk #(
    parameter int unsigned ACT_CYCLES = 300,
    parameter int unsigned TMR_CYCLES = 100
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Bus side
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // Buffer and modem side
    input wire logic mem_rd_out,
    input wire bsc_pkg::bsc_modem_in_s modem_in,
    input wire bsc_pkg::bsc_modem_out_s modem_out,
    input wire logic irq_out
);
    logic wr_hit;
    logic cmd_wr_reg;
    logic oc_wr_reg;
    logic dtr_exp_reg;
    assign wr_hit = hsel_in && hreadyout_out && htrans_in[1] && hwrite_in;
    // Data phases of command and control writes
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cmd_wr_reg <= 1'b0;
            oc_wr_reg <= 1'b0;
        end
        else
        begin
            cmd_wr_reg <= wr_hit && haddr_in == 32'h00000000;
            oc_wr_reg <= wr_hit && haddr_in == 32'h00000004;
        end
    end
    // Expected terminal ready level
    always_ff @(posedge clk_in)
    begin
        if (oc_wr_reg)
            dtr_exp_reg <= hwdata_in[4];
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_TXD_MARK: assert property (!modem_out.rts |-> modem_out.txd)
        else $error("txd left mark with rts low");
    AST_FETCH_CTS: assert property (mem_rd_out |-> modem_out.rts && $past(modem_in.cts, 3))
        else $error("fetch without clear to send");
    AST_ONE_FETCH: assert property (mem_rd_out |=> !mem_rd_out)
        else $error("fetch strobe longer than one cycle");
    AST_CLR_ABORT: assert property (cmd_wr_reg && (hwdata_in[7] || hwdata_in[8])
        |=> !modem_out.rts && !modem_out.dtr && modem_out.txd ##1 irq_out)
        else $error("clear did not abort");
    AST_TX_RTS: assert property (cmd_wr_reg && hwdata_in[0] && !hwdata_in[7] && !hwdata_in[8]
        |=> modem_out.rts)
        else $error("transmit did not raise rts");
    AST_END_IRQ: assert property ($fell(modem_out.rts) |-> ##[0:1] irq_out)
        else $error("no interrupt after transmit end");
    AST_DTR_CTRL: assert property (oc_wr_reg |=> ##1 modem_out.dtr == dtr_exp_reg)
        else $error("dtr does not follow control");
    AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
    cover property (cmd_wr_reg && hwdata_in[0]);
    cover property ($fell(modem_out.rts));
    cover property (mem_rd_out);
endmodule
bind bsc_ctrl bsc_chk #(.ACT_CYCLES(ACT_CYCLES), .TMR_CYCLES(TMR_CYCLES)) i_chk (.*);

// ### bsc_modem.sv
// Partner model: buffer memory, modem handshake, gated transmit clock, line capture
`timescale 1ns/1ps
module bsc_modem (
    // Clock and bench controls
    input wire logic clk_in,
    input wire logic hold_in,
    input wire logic slow_in,
    input wire logic free_in,
    // Buffer memory port
    input wire logic [15:0] mem_addr_in,
    input wire logic mem_rd_in,
    output logic [7:0] mem_rdata_out,
    // Modem pins and capture
    input wire logic rts_in,
    input wire logic txd_in,
    output logic cts_out,
    output logic txc_out,
    output logic [31:0] rx_out,
    output int falls_out,
    output int reads_out
);
    logic [15:0] dly = 16'h0000;
    logic en;
    logic [7:0] bval;
    // Clear to send after a short or long delay
    always @(posedge clk_in)
        dly <= {dly[14:0], rts_in};
    assign cts_out = !hold_in && (slow_in ? dly[5] : dly[0]);
    // Clock idles high outside frames unless free_in forces it to run
    assign en = (rts_in && cts_out && dly[15]) || free_in;
    initial
    begin
        txc_out = 1'b1;
        falls_out = 0;
        reads_out = 0;
        #37;
        forever #400 txc_out = en ? ~txc_out : 1'b1;
    end
    // Byte stands with the strobe, inverted otherwise; buffer opens with two SYN
    assign bval = mem_addr_in[3:1] == 3'h0 ? 8'h16
        : {mem_addr_in[3:0], ~mem_addr_in[3:0]};
    assign mem_rdata_out = mem_rd_in ? bval : ~bval;
    always @(posedge clk_in)
        reads_out <= reads_out + (mem_rd_in ? 1 : 0);
    // Each fall samples the bit launched at the fall before
    always @(negedge txc_out)
    begin
        if (rts_in)
        begin
            rx_out <= {txd_in, rx_out[31:1]};
            falls_out <= falls_out + 1;
        end
    end
endmodule

// ### testbench.sv
// Self-checking bench of the sync transmit block
`timescale 1ns/1ps
module testbench;
    localparam int ACT = 300;
    localparam int TMR = 100;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hwrite = 1'b0;
    logic ri = 1'b0;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic free = 1'b0;
    logic [31:0] hrdata, q, rx;
    logic hready, hresp, mem_rd, irq, txc, cts;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata;
    int falls, reads, f0, fails = 0, cmp_count = 0, cyc = 0;
    int clr[5] = '{2, 3, 4, 7, 8};
    bsc_pkg::bsc_modem_in_s m_in;
    bsc_pkg::bsc_modem_out_s m_out;
    assign m_in = {txc, cts, 1'b1, ri};
    bsc_ctrl #(.ACT_CYCLES(ACT), .TMR_CYCLES(TMR)) i_bsc_ctrl (.clk_in(clk_in),
        .rstn_in(rstn_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .mem_addr_out(mem_addr), .mem_rd_out(mem_rd), .mem_rdata_in(mem_rdata),
        .modem_in(m_in), .modem_out(m_out), .irq_out(irq));
    bsc_modem i_bsc_modem (.clk_in(clk_in), .hold_in(hold), .slow_in(slow), .free_in(free),
        .mem_addr_in(mem_addr), .mem_rd_in(mem_rd), .mem_rdata_out(mem_rdata),
        .rts_in(m_out.rts), .txd_in(m_out.txd), .cts_out(cts), .txc_out(txc),
        .rx_out(rx), .falls_out(falls), .reads_out(reads));
    always #50 clk_in = ~clk_in;
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // One single transfer; read data is taken at the data-phase edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string s);
        bus(a, 1'b0, 32'h0);
        chk((q & m) === e, s);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cycle ceiling
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rd(8'h08, 32'hFF, 32'h82, "status reset");
        chk(irq === 1'b1, "no irq idle");
        rd(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped read");
        bus(8'h04, 1'b1, 32'h10);
        rd(8'h04, 32'hFF, 32'h10, "control readback");
        free <= 1'b1;
        repeat (40) @(posedge clk_in);
        free <= 1'b0;
        chk(m_out.txd === 1'b1 && m_out.dtr === 1'b1, "idle line");
        $display("test idle done");
        bus(8'h0C, 1'b1, 32'h0);
        bus(8'h10, 1'b1, 32'h3);
        hold <= 1'b1;
        // Transmit held off by cts, then aborted
        for (int b = 7; b <= 8; b++)
        begin
            bus(8'h00, 1'b1, 32'h1);
            rd(8'h08, 32'h80, 32'h0, "busy not shown");
            chk(m_out.rts === 1'b1 && irq === 1'b0, "rts or irq busy");
            f0 = reads;
            repeat (60) @(posedge clk_in);
            chk(reads == f0, "fetch before cts");
            bus(8'h00, 1'b1, 32'h1 << b);
            @(posedge clk_in);
            chk(m_out.rts === 1'b0 && m_out.txd === 1'b1 && m_out.dtr === 1'b0, "abort");
            rd(8'h08, 32'h80, 32'h80, "abort idle");
        end
        hold <= 1'b0;
        slow <= 1'b1;
        $display("test abort done");
        // Eight-bit frame, then seven bits with parity and LRC
        for (int k = 0; k < 2; k++)
        begin
            bus(8'h04, 1'b1, k ? 32'h60 : 32'h0);
            repeat (20) @(posedge clk_in);
            f0 = falls;
            bus(8'h00, 1'b1, 32'h1);
            repeat (3) @(posedge clk_in);
            for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk_in);
            chk(falls - f0 == (k ? 41 : 33), "bit count");
            chk(rx === (k ? 32'h91BCAD16 : 32'h3C2D1616), "line data");
            rd(8'h14, 32'hFFFF, 32'h3, "current addr");
            chk(m_out.rts === 1'b0 && irq === 1'b1, "end pins");
        end
        $display("test transmit done");
        bus(8'h00, 1'b1, 32'h2);
        repeat (ACT - 24) @(posedge clk_in);
        rd(8'h08, 32'h08, 32'h0, "activity early");
        repeat (40) @(posedge clk_in);
        rd(8'h08, 32'h08, 32'h08, "activity late");
        bus(8'h00, 1'b1, 32'h2);
        rd(8'h08, 32'h08, 32'h0, "activity kept");
        $display("test activity done");
        // Timer set, then cleared by each command
        foreach (clr[i])
        begin
            bus(8'h00, 1'b1, 32'h4);
            repeat (TMR - 24) @(posedge clk_in);
            rd(8'h08, 32'h10, 32'h0, "timer early");
            repeat (40) @(posedge clk_in);
            rd(8'h08, 32'h10, 32'h10, "timer late");
            bus(8'h00, 1'b1, 32'h1 << clr[i]);
            rd(8'h08, 32'h10, 32'h0, "timer kept");
        end
        $display("test timer done");
        bus(8'h04, 1'b1, 32'h1);
        ri <= 1'b1;
        repeat (8) @(posedge clk_in);
        rd(8'h08, 32'h01, 32'h01, "ring missed");
        ri <= 1'b0;
        repeat (8) @(posedge clk_in);
        bus(8'h00, 1'b1, 32'h42);
        rd(8'h08, 32'h01, 32'h01, "ring lost");
        bus(8'h00, 1'b1, 32'h80);
        rd(8'h08, 32'h01, 32'h0, "ring kept");
        $display("test ring done");
        wrap_up();
    end
endmodule
